// ### logic/mpcp_pkg.sv
// Constants shared by the multipoint region and current peak status block.
package mpcp_pkg;
    localparam int          NUM_PHASES      = 3;
    localparam int          SAMPLE_W        = 32;
    localparam int          PEAK_W          = 24;
    localparam int          REGION_W        = 4;
    localparam int          ADDR_W          = 12;
    localparam int          DATA_W          = 32;
    localparam int          PEAK_SHIFT      = 5;
    localparam logic [11:0] PHASE_A_CAL_REGION_OFS = 12'h021d;
    localparam logic [11:0] PHASE_B_CAL_REGION_OFS = 12'h023d;
    localparam logic [11:0] PHASE_C_CAL_REGION_OFS = 12'h025d;
    localparam logic [11:0] CURRENT_PEAK_HOLD_OFS  = 12'h0400;
    localparam logic [3:0]  REGION_RESET    = 4'hf;
    localparam logic [3:0]  REGION_DISABLED = 4'hf;
    localparam logic [3:0]  REGION_MAX      = 4'h4;
    localparam logic [23:0] PEAK_RESET      = 24'h00_0000;
    localparam logic [2:0]  PHASE_FLAGS_RESET = 3'h0;
    localparam int          PEAK_LSB        = 0;
    localparam int          PHASE_FLAGS_LSB = 24;
    localparam int          REGION_LSB      = 0;
endpackage : mpcp_pkg

// ### logic/mpcp_abs_scale.sv
// Magnitude of one processed current sample scaled down to the peak width.
`timescale 1ns/1ps
module mpcp_abs_scale #(
    parameter int SAMPLE_W = mpcp_pkg::SAMPLE_W,
    parameter int PEAK_W   = mpcp_pkg::PEAK_W,
    parameter int SHIFT    = mpcp_pkg::PEAK_SHIFT
) (
    // Sample in.
    input  wire logic [SAMPLE_W-1:0] sample,
    // Scaled magnitude out.
    output logic      [PEAK_W-1:0]   magnitude
);
    logic [SAMPLE_W-1:0] abs_val;
    logic [SAMPLE_W-1:0] shifted;

    always_comb begin
        if (sample[SAMPLE_W-1]) begin
            abs_val = ~sample + {{(SAMPLE_W-1){1'b0}}, 1'b1};
        end else begin
            abs_val = sample;
        end
        shifted = abs_val >> SHIFT;
        // Values above the field saturate instead of wrapping.
        if (|shifted[SAMPLE_W-1:PEAK_W]) begin
            magnitude = {PEAK_W{1'b1}};
        end else begin
            magnitude = shifted[PEAK_W-1:0];
        end
    end
endmodule : mpcp_abs_scale

// ### logic/mpcp_status.sv
// Read-only calibration region and current peak status registers.
//
// How it works
// - With multipoint compensation on, each phase reports its set index.
// - The region field holds the binary set index, zero through four.
// - With compensation off, or after reset, every region field reads F.
// - Phases A, B and C each have their own region register.
// - The peak field holds the largest absolute sample divided by 32.
// - Only channels enabled by the peak channel select enter the peak.
// - Bit 4 of the main configuration enables multipoint compensation.
`timescale 1ns/1ps
module mpcp_status (
    // Clock and reset.
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // Configuration bits from the main and peak configuration registers.
    input  wire logic        multipoint_comp_enable,
    input  wire logic [2:0]  peak_channel_select,
    // Active calibration set per phase from the region selector, A lowest.
    input  wire logic [11:0] phase_region_in,
    // Processed current samples, A lowest, and their strobe.
    input  wire logic        sample_valid,
    input  wire logic [95:0] current_samples,
    // Peak clear request.
    input  wire logic        peak_clear,
    // Host read port.
    input  wire logic        reg_rd,
    input  wire logic [11:0] reg_addr,
    output logic      [31:0] reg_rdata_q,
    output logic             reg_rvalid_q
);
    localparam int NP = mpcp_pkg::NUM_PHASES;
    localparam int RW = mpcp_pkg::REGION_W;
    localparam int PW = mpcp_pkg::PEAK_W;
    localparam int SW = mpcp_pkg::SAMPLE_W;

    logic [NP*RW-1:0] region_q;
    logic [NP*RW-1:0] region_d;
    logic [PW-1:0]    peak_q;
    logic [PW-1:0]    peak_d;
    logic [NP-1:0]    flags_q;
    logic [NP-1:0]    flags_d;
    logic [31:0]      rdata_d;
    logic             rvalid_d;
    logic [PW-1:0]    mag [NP];
    logic [PW-1:0]    best;
    logic [NP-1:0]    hits;
    logic [PW-1:0]    base_peak;
    logic [NP-1:0]    base_flags;

    ////////////////////////////////////////////////////////////////////////
    // Per-phase region fields and sample magnitudes.
    genvar g;
    generate
        for (g = 0; g < NP; g++) begin : g_phase
            always_comb begin
                if (!multipoint_comp_enable) begin
                    region_d[g*RW +: RW] = mpcp_pkg::REGION_DISABLED;
                end else begin
                    region_d[g*RW +: RW] = phase_region_in[g*RW +: RW];
                end
            end
            mpcp_abs_scale u_abs (
                .sample    (current_samples[g*SW +: SW]),
                .magnitude (mag[g])
            );
        end
    endgenerate

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            region_q <= {NP{mpcp_pkg::REGION_RESET}};
        end else begin
            region_q <= region_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Peak tracking.
    always_comb begin
        best = '0;
        hits = '0;
        for (int i = 0; i < NP; i++) begin
            if (peak_channel_select[i] && mag[i] > best) begin
                best = mag[i];
            end
        end
        for (int i = 0; i < NP; i++) begin
            hits[i] = peak_channel_select[i] && (mag[i] == best) &&
                      (best != '0);
        end
        // A clear in the same cycle as a sample still keeps that sample.
        base_peak  = peak_clear ? mpcp_pkg::PEAK_RESET : peak_q;
        base_flags = peak_clear ? mpcp_pkg::PHASE_FLAGS_RESET : flags_q;
        peak_d     = base_peak;
        flags_d    = base_flags;
        if (sample_valid && best > base_peak) begin
            peak_d  = best;
            flags_d = hits;
        end else if (sample_valid && best == base_peak && best != '0) begin
            flags_d = base_flags | hits;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            peak_q  <= mpcp_pkg::PEAK_RESET;
            flags_q <= mpcp_pkg::PHASE_FLAGS_RESET;
        end else begin
            peak_q  <= peak_d;
            flags_q <= flags_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Host read decode; unmapped and reserved bits read zero.
    always_comb begin
        rdata_d  = '0;
        rvalid_d = reg_rd;
        if (!reg_rd) begin
            rdata_d = '0;
        end else if (reg_addr == mpcp_pkg::PHASE_A_CAL_REGION_OFS) begin
            rdata_d[mpcp_pkg::REGION_LSB +: RW] = region_q[0 +: RW];
        end else if (reg_addr == mpcp_pkg::PHASE_B_CAL_REGION_OFS) begin
            rdata_d[mpcp_pkg::REGION_LSB +: RW] = region_q[RW +: RW];
        end else if (reg_addr == mpcp_pkg::PHASE_C_CAL_REGION_OFS) begin
            rdata_d[mpcp_pkg::REGION_LSB +: RW] = region_q[2*RW +: RW];
        end else if (reg_addr == mpcp_pkg::CURRENT_PEAK_HOLD_OFS) begin
            rdata_d[mpcp_pkg::PEAK_LSB +: PW]        = peak_q;
            rdata_d[mpcp_pkg::PHASE_FLAGS_LSB +: NP] = flags_q;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            reg_rdata_q  <= '0;
            reg_rvalid_q <= 1'b0;
        end else begin
            reg_rdata_q  <= rdata_d;
            reg_rvalid_q <= rvalid_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions.
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_region_enable_gate: assert property (
        multipoint_comp_enable |=> (region_q == $past(phase_region_in)))
        else $error("region not taken while enabled");
    a_region_disabled: assert property (
        !multipoint_comp_enable |=> (region_q == 12'hfff))
        else $error("region not F while disabled");
    a_region_a_read: assert property (
        (reg_rd && reg_addr == mpcp_pkg::PHASE_A_CAL_REGION_OFS) |=>
        (reg_rdata_q == {28'h000_0000, $past(region_q[3:0])}))
        else $error("phase A region readback wrong");
    a_region_b_read: assert property (
        (reg_rd && reg_addr == mpcp_pkg::PHASE_B_CAL_REGION_OFS) |=>
        (reg_rdata_q == {28'h000_0000, $past(region_q[7:4])}))
        else $error("phase B region readback wrong");
    a_region_c_read: assert property (
        (reg_rd && reg_addr == mpcp_pkg::PHASE_C_CAL_REGION_OFS) |=>
        (reg_rdata_q == {28'h000_0000, $past(region_q[11:8])}))
        else $error("phase C region readback wrong");
    a_region_index: assert property (
        (multipoint_comp_enable && phase_region_in[3:0] <= 4'h4) |=>
        (region_q[3:0] <= 4'h4))
        else $error("region index out of range");
    a_peak_monotone: assert property (
        !peak_clear |=> (peak_q >= $past(peak_q)))
        else $error("peak fell without clear");
    a_peak_clear: assert property (
        (peak_clear && !sample_valid) |=>
        (peak_q == 24'h00_0000 && flags_q == 3'h0))
        else $error("peak not cleared");
    a_peak_select: assert property (
        (sample_valid && peak_channel_select == 3'h0 && !peak_clear) |=>
        $stable(peak_q) && $stable(flags_q))
        else $error("peak moved with no channel selected");
    a_flags_nonzero: assert property (
        (flags_q != 3'h0) |-> (peak_q != 24'h00_0000))
        else $error("phase flags set with zero peak");
    a_peak_read: assert property (
        (reg_rd && reg_addr == mpcp_pkg::CURRENT_PEAK_HOLD_OFS) |=>
        (reg_rdata_q == {5'h00, $past(flags_q), $past(peak_q)}))
        else $error("peak readback wrong");
    a_unmapped_zero: assert property (
        (reg_rd && reg_addr != mpcp_pkg::PHASE_A_CAL_REGION_OFS &&
         reg_addr != mpcp_pkg::PHASE_B_CAL_REGION_OFS &&
         reg_addr != mpcp_pkg::PHASE_C_CAL_REGION_OFS &&
         reg_addr != mpcp_pkg::CURRENT_PEAK_HOLD_OFS) |=>
        (reg_rdata_q == 32'h0000_0000))
        else $error("unmapped read not zero");
    a_read_valid: assert property (
        reg_rd |=> reg_rvalid_q)
        else $error("read answer missing");
    a_read_idle: assert property (
        !reg_rd |=> (!reg_rvalid_q && reg_rdata_q == 32'h0000_0000))
        else $error("read port not idle");
endmodule : mpcp_status

// ### tb/mpcp_tb.sv
// Self-checking testbench for the region and current peak status block.
`timescale 1ns/1ps
`define CHK(got, exp) begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
        n_fail++; \
        $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
    end \
end
module testbench;
    logic        core_clk;
    logic        rst_n;
    logic        multipoint_comp_enable;
    logic [2:0]  peak_channel_select;
    logic [11:0] phase_region_in;
    logic        sample_valid;
    logic [95:0] current_samples;
    logic        peak_clear;
    logic        reg_rd;
    logic [11:0] reg_addr;
    logic [31:0] reg_rdata_q;
    logic        reg_rvalid_q;
    int          n_fail;
    int          cmp_count;

    mpcp_status uut (
        .core_clk(core_clk), .rst_n(rst_n),
        .multipoint_comp_enable(multipoint_comp_enable),
        .peak_channel_select(peak_channel_select),
        .phase_region_in(phase_region_in), .sample_valid(sample_valid),
        .current_samples(current_samples), .peak_clear(peak_clear),
        .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q)
    );

    ////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    task automatic give_verdict();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict

    task automatic rst_dut();
        rst_n = 1'b0;
        repeat (5) @(posedge core_clk);
        #1 rst_n = 1'b1;
    endtask : rst_dut

    // One read; the answer stands in the cycle after the request edge.
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        #1 reg_rd = 1'b1;
        reg_addr = a;
        @(posedge core_clk);
        #1 reg_rd = 1'b0;
        `CHK(reg_rvalid_q, 1'b1)
        `CHK(reg_rdata_q, exp)
    endtask : rd

    task automatic regs(input logic [3:0] a, b, c);
        rd(mpcp_pkg::PHASE_A_CAL_REGION_OFS, {28'h000_0000, a});
        rd(mpcp_pkg::PHASE_B_CAL_REGION_OFS, {28'h000_0000, b});
        rd(mpcp_pkg::PHASE_C_CAL_REGION_OFS, {28'h000_0000, c});
    endtask : regs

    task automatic smp(input logic [2:0] sel, input logic [31:0] a, b, c);
        @(posedge core_clk);
        #1 peak_channel_select = sel;
        current_samples = {c, b, a};
        sample_valid = 1'b1;
        @(posedge core_clk);
        #1 sample_valid = 1'b0;
    endtask : smp

    function automatic logic [31:0] pk(logic [2:0] f, logic [23:0] v);
        return {5'h00, f, v};
    endfunction : pk

    ////////////////////////////////////////////////////////////////////////
    initial begin
        #1_000_000;
        n_fail++;
        give_verdict();
    end

    initial begin
        n_fail = 0;
        cmp_count = 0;
        multipoint_comp_enable = 1'b0;
        peak_channel_select = 3'h0;
        phase_region_in = 12'h421;
        sample_valid = 1'b0;
        current_samples = '0;
        peak_clear = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 12'h000;
        rst_dut();
        regs(4'hf, 4'hf, 4'hf);
        rd(mpcp_pkg::CURRENT_PEAK_HOLD_OFS, 32'h0000_0000);
        rd(12'h0000, 32'h0000_0000);
        multipoint_comp_enable = 1'b1;
        regs(4'h1, 4'h2, 4'h4);
        phase_region_in = 12'h032;
        regs(4'h2, 4'h3, 4'h0);
        multipoint_comp_enable = 1'b0;
        regs(4'hf, 4'hf, 4'hf);
        smp(3'h1, 32'h0000_0400, 32'h0010_0000, 32'h0010_0000);
        rd(mpcp_pkg::CURRENT_PEAK_HOLD_OFS, pk(3'h1, 24'h00_0020));
        smp(3'h2, 32'h0000_0100, -32'sh0000_1000, 32'h0010_0000);
        rd(mpcp_pkg::CURRENT_PEAK_HOLD_OFS, pk(3'h2, 24'h00_0080));
        smp(3'h7, 32'h0000_0010, 32'h0000_0020, 32'h0000_0200);
        rd(mpcp_pkg::CURRENT_PEAK_HOLD_OFS, pk(3'h2, 24'h00_0080));
        smp(3'h7, 32'h0000_1000, 32'h0000_0000, -32'sh0000_1000);
        rd(mpcp_pkg::CURRENT_PEAK_HOLD_OFS, pk(3'h7, 24'h00_0080));
        @(posedge core_clk);
        #1 peak_clear = 1'b1;
        @(posedge core_clk);
        #1 peak_clear = 1'b0;
        rd(mpcp_pkg::CURRENT_PEAK_HOLD_OFS, 32'h0000_0000);
        smp(3'h0, 32'h0000_4000, 32'h0000_4000, 32'h0000_4000);
        rd(mpcp_pkg::CURRENT_PEAK_HOLD_OFS, 32'h0000_0000);
        smp(3'h4, 32'h0000_0000, 32'h0000_0000, 32'h8000_0000);
        rd(mpcp_pkg::CURRENT_PEAK_HOLD_OFS, pk(3'h4, 24'hff_ffff));
        @(posedge core_clk);
        #1 peak_clear = 1'b1;
        peak_channel_select = 3'h1;
        current_samples = {32'h0000_0000, 32'h0000_0000, 32'h0000_0040};
        sample_valid = 1'b1;
        @(posedge core_clk);
        #1 peak_clear = 1'b0;
        sample_valid = 1'b0;
        rd(mpcp_pkg::CURRENT_PEAK_HOLD_OFS, pk(3'h1, 24'h00_0002));
        multipoint_comp_enable = 1'b0;
        rst_dut();
        regs(4'hf, 4'hf, 4'hf);
        rd(mpcp_pkg::CURRENT_PEAK_HOLD_OFS, 32'h0000_0000);
        give_verdict();
    end
endmodule : testbench
